// File: logic/far_pkg.sv
// Package for the angle ramp and loop register block
package far_pkg;
    localparam logic [15:0] ADR_CTRL = 16'h40A0;
    localparam logic [15:0] ADR_LOOP = 16'h40A1;
    localparam logic [15:0] ADR_SPEED = 16'h40A8;
    localparam logic [15:0] ADR_ACCEL = 16'h40AA;
    localparam logic [15:0] ADR_CNT = 16'h40AC;
    localparam logic [15:0] ADR_SWSTEP = 16'h40AD;
    localparam logic [15:0] ADR_COMP = 16'h40AE;
    localparam logic [15:0] ADR_DMAX = 16'h40B0;
    localparam logic [15:0] ADR_DMIN = 16'h40B2;
    localparam logic [15:0] ADR_QMAX = 16'h40B4;
    localparam logic [15:0] ADR_QMIN = 16'h40B6;
    localparam logic [15:0] ADR_UD = 16'h40B8;
    localparam logic [15:0] ADR_UQ = 16'h40BA;
    localparam logic [15:0] ADR_ID = 16'h40BC;
    localparam logic [15:0] ADR_IQ = 16'h40BE;
    localparam logic [15:0] ADR_IBET = 16'h40C0;
    localparam logic [15:0] ADR_VBET = 16'h40C2;
    localparam logic [15:0] ADR_VALP = 16'h40C4;
    localparam logic [15:0] ADR_IC = 16'h40C6;
    localparam logic [15:0] ADR_IB = 16'h40C8;
    localparam logic [15:0] ADR_IA = 16'h40CA;
    localparam logic [15:0] ADR_THETA = 16'h40CC;
    localparam int CTRL_RAMP_BIT = 5;
    localparam int CTRL_SRC_BIT = 4;
    localparam int LOOP_DFRZ_BIT = 0;
    localparam logic [7:0] SWSTEP_RST = 8'h01;
    localparam logic [7:0] SWSTEP_RO_MASK = 8'h01;
    localparam logic [15:0] ACCEL_WR_MASK = 16'h7FFF;

    typedef enum logic [2:0] {
        MODE_TRACK = 3'b001,
        MODE_RAMP = 3'b010,
        MODE_SWITCH = 3'b100
    } far_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } far_sfr_s;

    typedef struct packed {
        logic signed [15:0] d_cur;
        logic signed [15:0] q_cur;
        logic signed [15:0] beta_cur;
        logic signed [15:0] beta_volt;
        logic signed [15:0] alpha_volt;
        logic signed [15:0] phase_c;
        logic signed [15:0] phase_b;
        logic signed [15:0] phase_a;
    } far_meas_s;
endpackage

// File: logic/far_angle_loop.sv
// Angle ramp generator, loop output clamps and readout registers
// Function
// - Speed is a signed 32-bit accumulator; register access hits its upper half.
// - Each ramp step adds zero-extended 15-bit acceleration to speed.
// - Each ramp step adds upper speed half to the 16-bit angle, wrapping.
// - One step per PWM cycle while ramping; stop after count limit times 256 steps, or after one step at count limit 0.
// - Ramp end clears ramp enable by hardware, then source select decides mode.
// - Without ramping, select 0 means forced angle, 1 means estimator angle.
// - After ramping, angle walks to new source by switch step, reset value 1.
// - Estimated mode angle is estimator angle plus signed compensation.
// - d-axis voltage is clamped between its min and max limit registers.
// - q-axis voltage is clamped between its min and max limit registers.
// - d-axis result sits in a signed read-write register.
// - d-axis freeze stops PI updates so software value is kept.
// - q-axis result sits in a signed read-write register.
// - Park d and q currents are signed read-only registers.
// - Inverse Park alpha and beta voltages are signed read-only registers.
// - Beta stator current is a signed read-only register.
// - Phase A, B and C currents are separate signed read-only registers.
// - Angle write sets forced angle; read returns angle in use.
// - Angles are signed 16-bit, full range spanning one electrical turn.
// - Speed is a signed angle increment; acceleration is unsigned, added 16 bits below its LSB.
`timescale 1ns/1ps
module far_angle_loop
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire far_pkg::far_sfr_s sfr_i,
    output logic [7:0] rdata_o,
    input wire logic pwm_tick_i,
    input wire logic signed [15:0] est_theta_i,
    input wire logic signed [15:0] pi_d_raw_i,
    input wire logic signed [15:0] pi_q_raw_i,
    input wire far_pkg::far_meas_s meas_i,
    output logic [15:0] theta_o,
    output logic signed [15:0] ud_o,
    output logic signed [15:0] uq_o,
    output logic ramp_active_o
);
    import far_pkg::*;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        hit = (a[15:1] == base[15:1]);
    endfunction

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic lo,
                                         input logic [7:0] d);
        wr16 = lo ? {old[15:8], d} : {d, old[7:0]};
    endfunction

    function automatic logic [7:0] sel8(input logic lo, input logic [15:0] v);
        sel8 = lo ? v[7:0] : v[15:8];
    endfunction

    function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                 input logic signed [15:0] mx,
                                                 input logic signed [15:0] mn);
        if (v > mx)
            clamp = mx;
        else if (v < mn)
            clamp = mn;
        else
            clamp = v;
    endfunction

    far_mode_e mode_q;
    logic [31:0] speed_q;
    logic [15:0] accel_q;
    logic [7:0] cnt_lim_q;
    logic [7:0] swstep_q;
    logic signed [15:0] comp_q;
    logic signed [15:0] dmax_q;
    logic signed [15:0] dmin_q;
    logic signed [15:0] qmax_q;
    logic signed [15:0] qmin_q;
    logic signed [15:0] ud_q;
    logic signed [15:0] uq_q;
    logic [15:0] theta_q;
    logic [15:0] forced_q;
    logic [15:0] cnt_q;
    logic src_est_q;
    logic dfrz_q;
    far_meas_s meas_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_d;
    logic tick;
    logic lo;
    logic ctrl_wr;
    logic [15:0] cnt_nx;
    logic [15:0] ramp_lim;
    logic ramp_done;
    logic [15:0] target;
    logic signed [15:0] diff;
    logic [15:0] diff_abs;
    logic [15:0] step16;

    assign tick = ce_i & pwm_tick_i;
    assign lo = sfr_i.addr[0];
    assign ctrl_wr = sfr_i.wr & (sfr_i.addr == ADR_CTRL);
    assign cnt_nx = cnt_q + 16'h0001;
    assign ramp_lim = {cnt_lim_q, 8'h00};
    assign ramp_done = (cnt_nx >= ramp_lim);
    assign step16 = {8'h00, swstep_q};
    // Compensation and difference wrap mod 2^16, so the short way round is taken
    assign target = src_est_q ? 16'(est_theta_i + comp_q) : forced_q;
    assign diff = $signed(target - theta_q);
    assign diff_abs = diff[15] ? 16'(-diff) : diff;

    // Mode sequencing; a software write to the control byte wins over ramp end
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            mode_q <= MODE_TRACK;
            cnt_q <= 16'h0000;
            src_est_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (ctrl_wr)
            begin
                mode_q <= sfr_i.wdata[CTRL_RAMP_BIT] ? MODE_RAMP : MODE_TRACK;
                src_est_q <= sfr_i.wdata[CTRL_SRC_BIT];
                cnt_q <= 16'h0000;
            end
            else if (pwm_tick_i)
            begin
                case (mode_q)
                    MODE_RAMP:
                    begin
                        cnt_q <= cnt_nx;
                        if (ramp_done)
                            mode_q <= MODE_SWITCH;
                    end
                    MODE_SWITCH:
                    begin
                        if (diff_abs <= step16)
                            mode_q <= MODE_TRACK;
                    end
                    MODE_TRACK:
                        cnt_q <= 16'h0000;
                    default:
                        mode_q <= MODE_TRACK;
                endcase
            end
        end
    end

    // Angle in use
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            theta_q <= 16'h0000;
        else if (tick)
        begin
            case (mode_q)
                MODE_RAMP:
                    theta_q <= theta_q + speed_q[31:16];
                MODE_SWITCH:
                begin
                    if (diff_abs <= step16)
                        theta_q <= target;
                    else if (diff[15])
                        theta_q <= theta_q - step16;
                    else
                        theta_q <= theta_q + step16;
                end
                default:
                    theta_q <= target;
            endcase
        end
    end

    // Ramp speed accumulator; software reaches only the upper half
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            speed_q <= 32'h0000_0000;
        else if (ce_i)
        begin
            if (sfr_i.wr && hit(sfr_i.addr, ADR_SPEED))
                speed_q[31:16] <= wr16(speed_q[31:16], lo, sfr_i.wdata);
            else if (pwm_tick_i && mode_q == MODE_RAMP)
                speed_q <= speed_q + {17'h00000, accel_q[14:0]};
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            accel_q <= 16'h0000;
            cnt_lim_q <= 8'h00;
            swstep_q <= SWSTEP_RST;
            comp_q <= 16'sh0000;
            dmax_q <= 16'sh0000;
            dmin_q <= 16'sh0000;
            qmax_q <= 16'sh0000;
            qmin_q <= 16'sh0000;
            forced_q <= 16'h0000;
            dfrz_q <= 1'b0;
        end
        else if (ce_i && sfr_i.wr)
        begin
            if (hit(sfr_i.addr, ADR_ACCEL))
                accel_q <= wr16(accel_q, lo, sfr_i.wdata) & ACCEL_WR_MASK;
            if (sfr_i.addr == ADR_CNT)
                cnt_lim_q <= sfr_i.wdata;
            if (sfr_i.addr == ADR_SWSTEP)
                swstep_q <= sfr_i.wdata | SWSTEP_RO_MASK;
            if (hit(sfr_i.addr, ADR_COMP))
                comp_q <= wr16(comp_q, lo, sfr_i.wdata);
            if (hit(sfr_i.addr, ADR_DMAX))
                dmax_q <= wr16(dmax_q, lo, sfr_i.wdata);
            if (hit(sfr_i.addr, ADR_DMIN))
                dmin_q <= wr16(dmin_q, lo, sfr_i.wdata);
            if (hit(sfr_i.addr, ADR_QMAX))
                qmax_q <= wr16(qmax_q, lo, sfr_i.wdata);
            if (hit(sfr_i.addr, ADR_QMIN))
                qmin_q <= wr16(qmin_q, lo, sfr_i.wdata);
            if (hit(sfr_i.addr, ADR_THETA))
                forced_q <= wr16(forced_q, lo, sfr_i.wdata);
            if (sfr_i.addr == ADR_LOOP)
                dfrz_q <= sfr_i.wdata[LOOP_DFRZ_BIT];
        end
    end

    // Loop voltages; a software byte write in a tick cycle beats the controller
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            ud_q <= 16'sh0000;
            uq_q <= 16'sh0000;
        end
        else if (ce_i)
        begin
            if (sfr_i.wr && hit(sfr_i.addr, ADR_UD))
                ud_q <= wr16(ud_q, lo, sfr_i.wdata);
            else if (pwm_tick_i && !dfrz_q)
                ud_q <= clamp(pi_d_raw_i, dmax_q, dmin_q);
            if (sfr_i.wr && hit(sfr_i.addr, ADR_UQ))
                uq_q <= wr16(uq_q, lo, sfr_i.wdata);
            else if (pwm_tick_i)
                uq_q <= clamp(pi_q_raw_i, qmax_q, qmin_q);
        end
    end

    // Snapshot once per carrier so high and low byte reads belong together
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            meas_q <= '0;
        else if (tick)
            meas_q <= meas_i;
    end

    always_comb
    begin
        rd_d = 8'h00;
        if (sfr_i.addr == ADR_CTRL)
            rd_d = {2'b00, ramp_active_o, src_est_q, 4'h0};
        else if (sfr_i.addr == ADR_LOOP)
            rd_d = {7'h00, dfrz_q};
        else if (hit(sfr_i.addr, ADR_SPEED))
            rd_d = sel8(lo, speed_q[31:16]);
        else if (hit(sfr_i.addr, ADR_ACCEL))
            rd_d = sel8(lo, accel_q);
        else if (sfr_i.addr == ADR_CNT)
            rd_d = cnt_lim_q;
        else if (sfr_i.addr == ADR_SWSTEP)
            rd_d = swstep_q;
        else if (hit(sfr_i.addr, ADR_COMP))
            rd_d = sel8(lo, comp_q);
        else if (hit(sfr_i.addr, ADR_DMAX))
            rd_d = sel8(lo, dmax_q);
        else if (hit(sfr_i.addr, ADR_DMIN))
            rd_d = sel8(lo, dmin_q);
        else if (hit(sfr_i.addr, ADR_QMAX))
            rd_d = sel8(lo, qmax_q);
        else if (hit(sfr_i.addr, ADR_QMIN))
            rd_d = sel8(lo, qmin_q);
        else if (hit(sfr_i.addr, ADR_UD))
            rd_d = sel8(lo, ud_q);
        else if (hit(sfr_i.addr, ADR_UQ))
            rd_d = sel8(lo, uq_q);
        else if (hit(sfr_i.addr, ADR_ID))
            rd_d = sel8(lo, meas_q.d_cur);
        else if (hit(sfr_i.addr, ADR_IQ))
            rd_d = sel8(lo, meas_q.q_cur);
        else if (hit(sfr_i.addr, ADR_IBET))
            rd_d = sel8(lo, meas_q.beta_cur);
        else if (hit(sfr_i.addr, ADR_VBET))
            rd_d = sel8(lo, meas_q.beta_volt);
        else if (hit(sfr_i.addr, ADR_VALP))
            rd_d = sel8(lo, meas_q.alpha_volt);
        else if (hit(sfr_i.addr, ADR_IC))
            rd_d = sel8(lo, meas_q.phase_c);
        else if (hit(sfr_i.addr, ADR_IB))
            rd_d = sel8(lo, meas_q.phase_b);
        else if (hit(sfr_i.addr, ADR_IA))
            rd_d = sel8(lo, meas_q.phase_a);
        else if (hit(sfr_i.addr, ADR_THETA))
            rd_d = sel8(lo, theta_q);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            rdata_q <= 8'h00;
        else if (ce_i && sfr_i.rd)
            rdata_q <= rd_d;
        else if (ce_i)
            rdata_q <= 8'h00;
    end

    assign rdata_o = rdata_q;
    assign theta_o = theta_q;
    assign ud_o = ud_q;
    assign uq_o = uq_q;
    assign ramp_active_o = (mode_q == MODE_RAMP);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    logic spd_wr;
    assign spd_wr = sfr_i.wr & hit(sfr_i.addr, ADR_SPEED);

    chk_speed_accum: assert property (
        tick && mode_q == MODE_RAMP && !spd_wr
        |=> speed_q == $past(speed_q) + {17'h00000, $past(accel_q[14:0])})
        else $error("ramp speed did not add acceleration");
    chk_theta_step: assert property (
        tick && mode_q == MODE_RAMP
        |=> theta_q == 16'($past(theta_q) + $past(speed_q[31:16])))
        else $error("ramp angle did not advance by speed");
    chk_ramp_end: assert property (
        tick && mode_q == MODE_RAMP && ramp_done && !ctrl_wr
        |=> !ramp_active_o && mode_q == MODE_SWITCH)
        else $error("ramp did not end at count limit");
    chk_ramp_count: assert property (
        tick && mode_q == MODE_RAMP && !ramp_done && !ctrl_wr
        |=> ramp_active_o && cnt_q == $past(cnt_nx))
        else $error("ramp step count wrong");
    chk_forced_src: assert property (
        tick && mode_q == MODE_TRACK && !src_est_q
        |=> theta_q == $past(forced_q))
        else $error("forced angle not used");
    chk_est_comp: assert property (
        tick && mode_q == MODE_TRACK && src_est_q
        |=> theta_q == 16'($past(est_theta_i) + $past(comp_q)))
        else $error("estimated angle plus compensation not used");
    chk_d_clamp: assert property (
        tick && !dfrz_q && !(sfr_i.wr && hit(sfr_i.addr, ADR_UD)) && dmin_q <= dmax_q
        |=> ud_q <= $past(dmax_q) && ud_q >= $past(dmin_q))
        else $error("d-axis voltage outside limits");
    chk_q_clamp: assert property (
        tick && !(sfr_i.wr && hit(sfr_i.addr, ADR_UQ)) && qmin_q <= qmax_q
        |=> uq_q <= $past(qmax_q) && uq_q >= $past(qmin_q))
        else $error("q-axis voltage outside limits");
    chk_d_freeze: assert property (
        ce_i && dfrz_q && !(sfr_i.wr && hit(sfr_i.addr, ADR_UD)) |=> $stable(ud_q))
        else $error("frozen d-axis voltage changed");
    chk_speed_read: assert property (
        ce_i && sfr_i.rd && sfr_i.addr == ADR_SPEED ##1 1'b1
        |-> rdata_o == $past(speed_q[31:24]))
        else $error("speed read did not return upper byte");

    cov_ramp_end: cover property (tick && mode_q == MODE_RAMP ##1 mode_q == MODE_SWITCH);
    cov_switch_done: cover property (mode_q == MODE_SWITCH ##1 mode_q == MODE_TRACK);
    cov_d_clamp_hit: cover property (tick && !dfrz_q && pi_d_raw_i > dmax_q);
endmodule // far_angle_loop

// File: dv/far_bridge_model.sv
// Behavioural inverter bridge with sampling ADC that feeds the angle loop block
`timescale 1ns/1ps
module far_bridge_model
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic fire_i,
    output logic pwm_tick_o,
    output far_pkg::far_meas_s meas_o
);
    import far_pkg::*;
    localparam logic [127:0] PAT = 128'h8123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic [7:0] cnt_q;
    // One carrier tick per request; samples only move with a tick, as a real ADC would
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pwm_tick_o <= 1'b0;
            cnt_q <= 8'h00;
            meas_o <= '0;
        end
        else
        begin
            pwm_tick_o <= fire_i;
            if (fire_i)
            begin
                cnt_q <= cnt_q + 8'h01;
                // Both signs in every field, so swapped bytes show
                meas_o <= far_meas_s'({16{cnt_q + 8'h01}} ^ PAT);
            end
        end
    end
endmodule // far_bridge_model

// File: dv/far_angle_loop_tb.sv
// Self-checking bench for the angle ramp and loop register block
`timescale 1ns/1ps
module far_angle_loop_tb;
    import far_pkg::*;
    typedef struct {logic [15:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} far_row_s;
    logic clk_sys_i;
    logic reset_i;
    logic ce_i;
    logic fire;
    logic tick;
    logic ramp;
    far_sfr_s sfr;
    logic [7:0] rdata;
    logic signed [15:0] est;
    logic signed [15:0] pid;
    logic signed [15:0] piq;
    logic signed [15:0] ud;
    logic signed [15:0] uq;
    logic [15:0] theta;
    far_meas_s meas;
    int n_mismatch;
    int comparisons;
    logic [7:0] b;
    logic [15:0] v;
    logic [31:0] sp;
    logic [15:0] th;
    logic [15:0] w;
    far_row_s rows [14];
    logic [15:0] raw [4];
    logic [15:0] exd [4];
    logic [15:0] exq [4];

    far_angle_loop dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .sfr_i(sfr),
        .rdata_o(rdata), .pwm_tick_i(tick), .est_theta_i(est), .pi_d_raw_i(pid),
        .pi_q_raw_i(piq), .meas_i(meas), .theta_o(theta), .ud_o(ud), .uq_o(uq),
        .ramp_active_o(ramp));
    far_bridge_model bridge (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fire_i(fire),
        .pwm_tick_o(tick), .meas_o(meas));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        sfr.addr <= a;
        sfr.wdata <= d;
        sfr.wr <= 1'b1;
        @(posedge clk_sys_i);
        sfr.wr <= 1'b0;
    endtask

    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a | 16'h0001, d[7:0]);
    endtask

    // Read data stand only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        sfr.addr <= a;
        sfr.rd <= 1'b1;
        @(posedge clk_sys_i);
        sfr.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        logic [7:0] hi;
        logic [7:0] lo;
        rd(a, hi);
        rd(a | 16'h0001, lo);
        d = {hi, lo};
    endtask

    // One carrier cycle; outputs are sampled after the edge that took the tick
    task automatic step();
        @(posedge clk_sys_i);
        fire <= 1'b1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        reset_i = 1'b1;
        ce_i = 1'b1;
        fire = 1'b0;
        sfr = '0;
        est = 16'h0000;
        pid = 16'h0000;
        piq = 16'h0000;
        rows = '{'{ADR_SPEED, 8'h00, 8'hAB, 8'hAB}, '{16'h40A9, 8'h00, 8'hCD, 8'hCD},
            '{ADR_ACCEL, 8'h00, 8'hFF, 8'h7F}, '{16'h40AB, 8'h00, 8'hFF, 8'hFF},
            '{ADR_CNT, 8'h00, 8'h5A, 8'h5A}, '{ADR_SWSTEP, 8'h01, 8'h40, 8'h41},
            '{ADR_COMP, 8'h00, 8'h80, 8'h80}, '{16'h40B1, 8'h00, 8'h33, 8'h33},
            '{ADR_QMIN, 8'h00, 8'hC4, 8'hC4}, '{16'h40B9, 8'h00, 8'h5B, 8'h5B},
            '{ADR_UQ, 8'h00, 8'hA6, 8'hA6}, '{ADR_ID, 8'h00, 8'h77, 8'h00},
            '{16'h40CB, 8'h00, 8'h77, 8'h00}, '{16'h40D0, 8'h00, 8'h77, 8'h00}};
        raw = '{16'h7000, 16'h8000, 16'h0050, 16'hFF80};
        exd = '{16'h0100, 16'hFF00, 16'h0050, 16'hFF80};
        exq = '{16'h0200, 16'hFE00, 16'h0050, 16'hFF80};
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        foreach (rows[i])
        begin
            rd(rows[i].a, b);
            chk({8'h00, b}, {8'h00, rows[i].r});
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, b);
            chk({8'h00, b}, {8'h00, rows[i].e});
        end
        $display("Test register table finished");
        // Angle read gives the angle in use, so a fresh write is seen only after a tick
        wr16(ADR_THETA, 16'h5555);
        rd16(ADR_THETA, v);
        chk(v, 16'h0000);
        step();
        rd16(ADR_THETA, v);
        chk(v, 16'h5555);
        step();
        for (int k = 0; k < 8; k++)
        begin
            rd16(ADR_ID + 16'(2 * k), v);
            chk(v, meas[127 - 16 * k -: 16]);
        end
        $display("Test angle and readouts finished");
        wr16(ADR_DMAX, 16'h0100);
        wr16(ADR_DMIN, 16'hFF00);
        wr16(ADR_QMAX, 16'h0200);
        wr16(ADR_QMIN, 16'hFE00);
        foreach (raw[i])
        begin
            @(posedge clk_sys_i);
            pid <= raw[i];
            piq <= raw[i];
            step();
            chk(ud, exd[i]);
            chk(uq, exq[i]);
        end
        rd16(ADR_UD, v);
        chk(v, 16'hFF80);
        rd16(ADR_UQ, v);
        chk(v, 16'hFF80);
        wr(ADR_LOOP, 8'h01);
        wr16(ADR_UD, 16'h1234);
        @(posedge clk_sys_i);
        pid <= 16'h0050;
        piq <= 16'h0010;
        step();
        chk(ud, 16'h1234);
        chk(uq, 16'h0010);
        wr(ADR_LOOP, 8'h00);
        step();
        chk(ud, 16'h0050);
        $display("Test clamps and freeze finished");
        wr16(ADR_COMP, 16'h7000);
        @(posedge clk_sys_i);
        est <= 16'h2000;
        wr(ADR_CTRL, 8'h10);
        step();
        chk(theta, 16'h9000);
        rd16(ADR_THETA, v);
        chk(v, 16'h9000);
        $display("Test estimated angle finished");
        wr(ADR_CTRL, 8'h00);
        wr16(ADR_THETA, 16'h0000);
        step();
        wr16(ADR_SPEED, 16'h0123);
        wr16(ADR_ACCEL, 16'h0080);
        wr(ADR_CNT, 8'h01);
        sp = 32'h0123_0000;
        th = 16'h0000;
        wr(ADR_CTRL, 8'h20);
        for (int i = 0; i < 256; i++)
        begin
            step();
            th = th + sp[31:16];
            sp = sp + 32'h0000_0080;
            chk(theta, th);
            chk({15'h0000, ramp}, {15'h0000, i != 255});
        end
        rd16(ADR_SPEED, v);
        chk(v, sp[31:16]);
        rd(ADR_CTRL, b);
        chk({15'h0000, b[CTRL_RAMP_BIT]}, 16'h0000);
        // Switch step register holds 0x41 here, so the walk lands on its fourth tick
        wr16(ADR_THETA, th + 16'h0100);
        for (int j = 1; j <= 5; j++)
        begin
            step();
            chk(theta, (j < 4) ? th + 16'(16'h41 * j) : th + 16'h0100);
        end
        $display("Test ramp and switch finished");
        // Clock enable low: a write and a carrier tick must both leave no trace
        rd16(ADR_IA, v);
        chk(v, meas[15:0]);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(ADR_SWSTEP, 8'h10);
        step();
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rd(ADR_SWSTEP, b);
        chk({8'h00, b}, 16'h0041);
        rd16(ADR_IA, w);
        chk(w, v);
        $display("Test clock enable finished");
        // Reset in mid-ramp; the first access follows right after release
        wr(ADR_CTRL, 8'h20);
        #1;
        chk({15'h0000, ramp}, 16'h0001);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1;
        chk(theta, 16'h0000);
        chk(ud, 16'h0000);
        chk(uq, 16'h0000);
        chk({15'h0000, ramp}, 16'h0000);
        rd(ADR_SWSTEP, b);
        chk({8'h00, b}, 16'h0001);
        rd16(ADR_SPEED, v);
        chk(v, 16'h0000);
        $display("Test mid-run reset finished");
        report_and_stop();
    end
endmodule // far_angle_loop_tb
